// ==== hw/sfm_map.svh ====
`ifndef SFM_MAP_SVH
`define SFM_MAP_SVH

// serial frame geometry
`define SFM_WORD_W 16
`define SFM_BYTE_W 8
`define SFM_CNT_W 8
`define SFM_CNT_MIN 8'h10
`define SFM_CNT_MAX 8'hFF
`define SFM_CH_N 5

// status byte layout: channel flag index placed at each output bit
`define SFM_POS_CH4 3
`define SFM_POS_CH3 2
`define SFM_POS_CH2 1
`define SFM_POS_CH1 0
`define SFM_POS_CH5 4
`define SFM_PAD_ZERO 3'h0

// reset values
`define SFM_WORD_RST 16'h0000
`define SFM_BYTE_RST 8'h00
`define SFM_FLAG_RST 5'h00

// sampling timebase
`define SFM_CLK_NS 25
`define SFM_T_SAM_NS 72000
`define SFM_T_WINDOW_MS 53
`define SFM_SAM_W 12
`define SFM_WIN_W 22

`endif

// ==== hw/sfm_pkg.sv ====
package sfm_pkg;
`include "sfm_map.svh"

   // transfer phase, gray coded along idle -> shift -> commit
   typedef enum logic [1:0] {
      SFM_IDLE = 2'h0,
      SFM_SHIFT = 2'h1,
      SFM_COMMIT = 2'h3
   } sfm_phase_t;

   // host side serial pins
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic si;
   } sfm_pins_t;

   // fault latch state
   typedef struct packed {
      logic [`SFM_CH_N-1:0] sy1;
      logic [`SFM_CH_N-1:0] sy2;
      logic [`SFM_CH_N-1:0] flags;
   } sfm_latch_st_t;

   // serial slave state
   typedef struct packed {
      logic [1:0] cs_sy;
      logic cs_q;
      logic [1:0] ck_sy;
      logic ck_q;
      logic [1:0] si_sy;
      logic [1:0] rs_sy;
      sfm_phase_t phase;
      logic [`SFM_WORD_W-1:0] sr;
      logic so_bit;
      logic [`SFM_CNT_W-1:0] cnt;
      logic ovf;
      logic [`SFM_BYTE_W-1:0] prev_byte;
      logic [`SFM_WORD_W-1:0] cmd_word;
      logic cmd_valid;
      logic clr_faults;
      logic [`SFM_SAM_W-1:0] sam_cnt;
      logic [`SFM_WIN_W-1:0] win_cnt;
      logic sam_tick;
      logic win_tick;
   } sfm_spi_st_t;

endpackage

// ==== hw/sfm_fault_latch.sv ====
`timescale 1ns/100ps
`include "sfm_map.svh"
module sfm_fault_latch
   import sfm_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic nrst, // async reset, active low
   input wire logic [`SFM_CH_N-1:0] mon_raw, // fault levels from monitor channels
   input wire logic clr, // one-cycle clear after an accepted transfer
   input wire logic hold_clr, // reset pin level, holds flags clear
   output logic [`SFM_CH_N-1:0] flags // latched fault flags
);
   sfm_latch_st_t st;
   sfm_latch_st_t next_st;

   // two-flop synchroniser then sticky latch; a new fault wins over clr
   always_comb begin
      next_st = st;
      next_st.sy1 = mon_raw;
      next_st.sy2 = st.sy1;
      if (hold_clr) begin
         next_st.flags = `SFM_FLAG_RST;
      end else if (clr) begin
         next_st.flags = st.sy2;
      end else begin
         next_st.flags = st.flags | st.sy2;
      end
   end

   // state register
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign flags = st.flags;

   chk_flag_clear: assert property (
      @(posedge clk) disable iff (!nrst)
      (clr && !hold_clr && st.sy2 == `SFM_FLAG_RST) |=> (flags == `SFM_FLAG_RST))
      else $error("fault flags not cleared after accepted transfer");

   chk_reset_clear: assert property (
      @(posedge clk) disable iff (!nrst)
      hold_clr[*2] |-> (flags == `SFM_FLAG_RST))
      else $error("fault flags survive reset pin");

   chk_set_wins: assert property (
      @(posedge clk) disable iff (!nrst)
      (!hold_clr && (st.sy2 != `SFM_FLAG_RST)) |=> ((flags & $past(st.sy2)) == $past(st.sy2)))
      else $error("fault event lost");
endmodule

// ==== hw/sfm_spi_slave.sv ====
`timescale 1ns/100ps
`include "sfm_map.svh"
// Function
// - status shifts out while host bits shift in, full duplex
// - 16-bit exchange returns status byte, then previous received byte
// - accept only 16 plus multiple of 8 clocks, ignore others; frames of 256 clocks or more are ignored too
// - input bit captured on every rising serial clock edge
// - output changes on falling edge; host samples on next rising
// - while deselected ignore clock and input, output high impedance
// - select falling edge enables output and loads fault status
// - select rising edge tri-states output and takes received word
// - status bit zero for good channel, one for faulted channel
// - both directions most significant bit first, in order
// - active-high reset pin clears fault flags and registers
// - sample period and window timed from own clock, not serial clock
// - bits 15 to 11 carry channels 4,3,2,1,5
// - accepted transfer end clears all latched fault flags
// - reset pin high tri-states output so pull-up reads ones
// - status byte is five fault bits over three low zeros
module sfm_spi_slave
   import sfm_pkg::*;
#(
   parameter int unsigned WIN_CYC = `SFM_T_WINDOW_MS * 1000000 / `SFM_CLK_NS, // window
   parameter int unsigned SAM_CYC = `SFM_T_SAM_NS / `SFM_CLK_NS // sample period
) (
   input wire logic clk, // system clock, 40 MHz
   input wire logic nrst, // async reset, active low
   input wire logic reset_pin, // device reset pin, active high
   input wire sfm_pins_t pins, // chip select, serial clock, serial input
   input wire logic [`SFM_CH_N-1:0] solenoid_monitor_inputs, // channel fault levels
   output logic so, // serial output data
   output logic so_oe_n, // serial output enable, low while driving
   output logic [`SFM_WORD_W-1:0] cmd_word, // last accepted received word
   output logic cmd_valid, // one-cycle pulse on accepted word
   output logic [`SFM_CH_N-1:0] fault_flags, // latched fault flags
   output logic sam_tick, // one-cycle sample strobe
   output logic win_tick // one-cycle detection window strobe
);
   sfm_spi_st_t st;
   sfm_spi_st_t next_st;
   logic [`SFM_CH_N-1:0] flags;
   logic cs_fall, cs_rise, ck_rise, ck_fall, rst_pin;

   // pack flags into the status byte, zeros in low bits
   function automatic logic [`SFM_BYTE_W-1:0] status_of(input logic [`SFM_CH_N-1:0] f);
      status_of = {f[`SFM_POS_CH4], f[`SFM_POS_CH3], f[`SFM_POS_CH2],
                   f[`SFM_POS_CH1], f[`SFM_POS_CH5], `SFM_PAD_ZERO};
   endfunction

   // frame length is 16 plus whole bytes, and no overflow
   function automatic logic count_ok(input logic [`SFM_CNT_W-1:0] c, input logic o);
      count_ok = !o && (c >= `SFM_CNT_MIN) && (c[2:0] == `SFM_PAD_ZERO);
   endfunction

   // fault latch: synchronised, sticky, cleared by accepted frames or reset pin
   sfm_fault_latch u_latch (
      .clk(clk),
      .nrst(nrst),
      .mon_raw(solenoid_monitor_inputs),
      .clr(st.clr_faults),
      .hold_clr(rst_pin),
      .flags(flags)
   );

   // edge detection on synchronised pins
   assign cs_fall = !st.cs_sy[1] && st.cs_q;
   assign cs_rise = st.cs_sy[1] && !st.cs_q;
   assign ck_rise = st.ck_sy[1] && !st.ck_q;
   assign ck_fall = !st.ck_sy[1] && st.ck_q;
   assign rst_pin = st.rs_sy[1];

   // next state: synchronisers, frame sequencer, timebase
   always_comb begin
      next_st = st;
      next_st.cs_sy = {st.cs_sy[0], pins.cs_n};
      next_st.cs_q = st.cs_sy[1];
      next_st.ck_sy = {st.ck_sy[0], pins.sclk};
      next_st.ck_q = st.ck_sy[1];
      // input rides the same two-flop delay as the clock so they stay aligned
      next_st.si_sy = {st.si_sy[0], pins.si};
      next_st.rs_sy = {st.rs_sy[0], reset_pin};
      next_st.cmd_valid = 1'h0;
      next_st.clr_faults = 1'h0;
      unique case (st.phase)
         SFM_IDLE: begin
            // clock and input activity are ignored here
            if (cs_fall && !rst_pin) begin
               next_st.phase = SFM_SHIFT;
               next_st.sr = {status_of(flags), st.prev_byte};
               next_st.so_bit = next_st.sr[`SFM_WORD_W-1];
               next_st.cnt = '0;
               next_st.ovf = 1'h0;
            end
         end
         SFM_SHIFT: begin
            if (rst_pin) begin
               next_st.phase = SFM_IDLE;
            end else if (cs_rise) begin
               next_st.phase = SFM_COMMIT;
            end else begin
               if (ck_rise) begin
                  next_st.sr = {st.sr[`SFM_WORD_W-2:0], st.si_sy[1]};
                  if (st.cnt == `SFM_CNT_MAX) begin
                     next_st.ovf = 1'h1;
                  end
                  next_st.cnt = st.cnt + 1'h1;
               end
               if (ck_fall) begin
                  next_st.so_bit = st.sr[`SFM_WORD_W-1];
               end
            end
         end
         SFM_COMMIT: begin
            next_st.phase = SFM_IDLE;
            if (count_ok(st.cnt, st.ovf)) begin
               next_st.prev_byte = st.sr[`SFM_BYTE_W-1:0];
               next_st.cmd_word = st.sr;
               next_st.cmd_valid = 1'h1;
               next_st.clr_faults = 1'h1;
            end
         end
         default: begin
            next_st.phase = SFM_IDLE;
         end
      endcase
      if (rst_pin) begin
         next_st.prev_byte = `SFM_BYTE_RST;
         next_st.cmd_word = `SFM_WORD_RST;
      end
      // sample and window strobes from the system clock only
      next_st.sam_tick = 1'h0;
      next_st.win_tick = 1'h0;
      if (st.sam_cnt == `SFM_SAM_W'(SAM_CYC - 1)) begin
         next_st.sam_cnt = '0;
         next_st.sam_tick = 1'h1;
      end else begin
         next_st.sam_cnt = st.sam_cnt + 1'h1;
      end
      if (st.win_cnt == `SFM_WIN_W'(WIN_CYC - 1)) begin
         next_st.win_cnt = '0;
         next_st.win_tick = 1'h1;
      end else begin
         next_st.win_cnt = st.win_cnt + 1'h1;
      end
   end

   // state register; pins idle high for select, low for clock
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
         st.cs_sy <= 2'h3;
         st.cs_q <= 1'h1;
      end else begin
         st <= next_st;
      end
   end

   // outputs
   assign so = st.so_bit;
   assign so_oe_n = !(st.phase == SFM_SHIFT && !rst_pin);
   assign cmd_word = st.cmd_word;
   assign cmd_valid = st.cmd_valid;
   assign fault_flags = flags;
   assign sam_tick = st.sam_tick;
   assign win_tick = st.win_tick;

   // checks
   sequence s_cs_fall;
      (st.phase == SFM_IDLE) && cs_fall && !rst_pin;
   endsequence

   sequence s_commit;
      st.phase == SFM_COMMIT;
   endsequence

   chk_idle_tristate: assert property (
      @(posedge clk) disable iff (!nrst)
      (st.phase != SFM_SHIFT) |-> so_oe_n)
      else $error("serial output driven while deselected");

   chk_status_load: assert property (
      @(posedge clk) disable iff (!nrst)
      s_cs_fall |=> (!so_oe_n && st.sr[15:8] == status_of($past(flags))
                     && st.sr[7:0] == $past(st.prev_byte) && st.cnt == '0))
      else $error("status not loaded at select fall");

   chk_status_pad: assert property (
      @(posedge clk) disable iff (!nrst)
      s_cs_fall |=> (st.sr[10:8] == `SFM_PAD_ZERO && so == st.sr[15]))
      else $error("status byte low bits not zero");

   chk_shift_in: assert property (
      @(posedge clk) disable iff (!nrst)
      (st.phase == SFM_SHIFT && ck_rise && !cs_rise && !rst_pin)
      |=> (st.sr[0] == $past(st.si_sy[1]) && st.sr[15:1] == $past(st.sr[14:0])))
      else $error("input bit not shifted in on rising clock");

   chk_out_on_fall: assert property (
      @(posedge clk) disable iff (!nrst)
      (st.phase == SFM_SHIFT && ck_fall && !cs_rise && !rst_pin)
      |=> (so == $past(st.sr[15])))
      else $error("output not updated on falling clock");

   chk_accept_frame: assert property (
      @(posedge clk) disable iff (!nrst)
      (s_commit ##0 (count_ok(st.cnt, st.ovf) && !rst_pin))
      |=> (cmd_valid && st.prev_byte == $past(st.sr[7:0]) && st.clr_faults))
      else $error("accepted frame not taken over");

   chk_reject_frame: assert property (
      @(posedge clk) disable iff (!nrst)
      (s_commit ##0 !count_ok(st.cnt, st.ovf))
      |=> (!cmd_valid && !st.clr_faults ##1 !st.clr_faults))
      else $error("bad length frame acted on");

   chk_reset_pin_off: assert property (
      @(posedge clk) disable iff (!nrst)
      rst_pin |-> so_oe_n ##1 (st.prev_byte == `SFM_BYTE_RST))
      else $error("output driven during reset pin");

   chk_sample_gap: assert property (
      @(posedge clk) disable iff (!nrst)
      st.sam_tick |=> !st.sam_tick [*8])
      else $error("sample strobe too frequent");
endmodule

// ==== bench/sfm_host_model.sv ====
`timescale 1ns/100ps
`include "sfm_map.svh"
module sfm_host_model
   import sfm_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic line, // serial output as seen on the pulled-up wire
   output sfm_pins_t pins // chip select, serial clock, serial input
);
   initial pins = '{cs_n: 1'b1, sclk: 1'b0, si: 1'b0};

   // one frame of n clocks, msb first both ways, serial clock period 8 clk
   task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
      rx = '0;
      @(negedge clk) pins.cs_n = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         pins.si = tx[i];
         repeat (4) @(negedge clk);
         pins.sclk = 1'b1;
         rx = {rx[30:0], line};
         repeat (4) @(negedge clk);
         pins.sclk = 1'b0;
      end
      repeat (4) @(negedge clk);
      pins.cs_n = 1'b1;
      // released input no longer shows its last bit
      pins.si = ~pins.si;
      repeat (8) @(negedge clk);
   endtask
endmodule

// ==== bench/sfm_spi_slave_tb.sv ====
`timescale 1ns/100ps
`include "sfm_map.svh"
module sfm_spi_slave_tb
   import sfm_pkg::*;
;
   logic clk = 1'b0;
   logic nrst;
   logic reset_pin;
   logic [`SFM_CH_N-1:0] mon;
   logic so;
   logic so_oe_n;
   logic [`SFM_WORD_W-1:0] cmd_word;
   logic cmd_valid;
   logic [`SFM_CH_N-1:0] fault_flags;
   logic sam_tick;
   logic win_tick;
   sfm_pins_t pins;
   wire logic line;
   logic [15:0] notes[$];
   int failures = 0;
   int samples_checked = 0;
   int sam_n = 0;
   int win_n = 0;

   always #12.5 clk = ~clk;
   // pull-up on the serial output wire
   assign line = so_oe_n ? 1'b1 : so;

   sfm_spi_slave #(.WIN_CYC(100), .SAM_CYC(20)) dut (
      .clk(clk), .nrst(nrst), .reset_pin(reset_pin), .pins(pins),
      .solenoid_monitor_inputs(mon), .so(so), .so_oe_n(so_oe_n), .cmd_word(cmd_word),
      .cmd_valid(cmd_valid), .fault_flags(fault_flags), .sam_tick(sam_tick),
      .win_tick(win_tick));

   sfm_host_model host (.clk(clk), .line(line), .pins(pins));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic conclude();
      if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   function automatic logic [7:0] stat(input logic [4:0] f);
      return {f[3], f[2], f[1], f[0], f[4], 3'h0};
   endfunction

   // accepted words are compared against the oldest note
   always @(negedge clk) begin
      if (cmd_valid === 1'b1) begin
         if (notes.size() == 0) check("cmd_valid", 32'h1, 32'h0);
         else check("cmd_word", 32'(cmd_word), 32'(notes.pop_front()));
      end
   end

   // tick counters, sampled mid-cycle where the strobes are settled
   always @(negedge clk) begin
      sam_n += int'(sam_tick === 1'b1);
      win_n += int'(win_tick === 1'b1);
   end

   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      conclude();
   end

   initial begin
      logic [31:0] rx;
      logic [31:0] tx;
      logic [4:0] f;
      logic [7:0] prev;
      int s0;
      int w0;
      int acc[6];
      int rej[4];
      acc = '{16, 16, 24, 32, 16, 16};
      rej = '{8, 15, 17, 23};
      nrst = 1'b0;
      reset_pin = 1'b0;
      mon = '0;
      prev = 8'h00;
      void'($urandom(96296));
      repeat (4) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      // accepted frames with random faults; second one is the first link echo check
      foreach (acc[k]) begin
         f = 5'($urandom);
         mon = f;
         repeat (6) @(negedge clk);
         mon = '0;
         repeat (2) @(negedge clk);
         check("flags set", 32'(fault_flags), 32'(f));
         tx = $urandom & (32'hFFFF_FFFF >> (32 - acc[k]));
         notes.push_back(tx[15:0]);
         host.xfer(acc[k], tx, rx);
         check("response", rx, ({16'h0, stat(f), prev} << (acc[k] - 16)) | (tx >> 16));
         prev = tx[7:0];
         repeat (4) @(negedge clk);
         check("flags cleared", 32'(fault_flags), 32'h0);
      end
      // refused counts keep flags and the previous byte
      f = 5'($urandom) | 5'h01;
      mon = f;
      repeat (6) @(negedge clk);
      mon = '0;
      foreach (rej[k]) begin
         host.xfer(rej[k], $urandom & (32'hFFFF_FFFF >> (32 - rej[k])), rx);
         check("status only", rx >> (rej[k] - 8), 32'(stat(f)));
         check("flags kept", 32'(fault_flags), 32'(f));
      end
      tx = 32'($urandom & 32'h0000_FFFF);
      notes.push_back(tx[15:0]);
      host.xfer(16, tx, rx);
      check("after refused", rx, {16'h0, stat(f), prev});
      // reset pin: flags cleared, responses all ones, frames refused
      mon = 5'h1F;
      repeat (6) @(negedge clk);
      mon = '0;
      reset_pin = 1'b1;
      repeat (6) @(negedge clk);
      check("reset flags", 32'(fault_flags), 32'h0);
      host.xfer(16, 32'h0000_A5C3, rx);
      check("reset response", rx, 32'h0000_FFFF);
      reset_pin = 1'b0;
      repeat (4) @(negedge clk);
      notes.push_back(16'h3C5A);
      host.xfer(16, 32'h0000_3C5A, rx);
      check("after reset", rx, 32'h0);
      // timebase runs from the system clock alone
      s0 = sam_n;
      w0 = win_n;
      repeat (200) @(negedge clk);
      check("sample ticks", 32'(sam_n - s0), 32'd10);
      check("window ticks", 32'(win_n - w0), 32'd2);
      check("notes left", 32'(notes.size()), 32'h0);
      conclude();
   end
endmodule
